// ===== inc/fp_bounce_pkg.sv
// Constants for the potential floating-point exception detector.
// Assumes exponents arrive as signed biased values wide enough to hold out-of-range sums.
package fp_bounce_pkg;

  localparam int exp_width = 13;

  // Operation codes presented with each issued instruction.
  typedef enum logic [4:0] {
    add_family_op = 5'h00,
    multiply_family_op = 5'h01,
    mul_acc_op = 5'h02,
    mul_sub_acc_op = 5'h03,
    neg_mul_acc_op = 5'h04,
    neg_mul_sub_acc_op = 5'h05,
    divide_op = 5'h06,
    square_root_op = 5'h07,
    copy_op = 5'h08,
    absolute_op = 5'h09,
    negate_op = 5'h0a,
    single_to_double_conv = 5'h0b,
    double_to_single_conv = 5'h0c,
    unsigned_int_to_float = 5'h0d,
    signed_int_to_float = 5'h0e,
    float_to_unsigned = 5'h0f,
    float_to_unsigned_trunc = 5'h10,
    float_to_signed = 5'h11,
    float_to_signed_trunc = 5'h12,
    compare_op = 5'h13
  } fp_op_t;

  // Rounding mode encoding.
  localparam logic [1:0] round_nearest = 2'h0;
  localparam logic [1:0] round_plus = 2'h1;
  localparam logic [1:0] round_minus = 2'h2;
  localparam logic [1:0] round_zero = 2'h3;

  // Overflow thresholds shared by like-sign addition, multiply and divide, and a separate one for narrowing.
  localparam logic signed [12:0] dp_over_min = 13'sh07fd;
  localparam logic signed [12:0] sp_over_min = 13'sh00fd;
  localparam logic signed [12:0] dp_sp_over_min = 13'sh047d;
  // Underflow thresholds: an exponent at or below these bounces.
  localparam logic signed [12:0] sp_under_like = 13'sh0000;
  localparam logic signed [12:0] dp_under_like = 13'sh0000;
  localparam logic signed [12:0] sp_under_unlike = 13'sh001f;
  localparam logic signed [12:0] dp_under_unlike = 13'sh003f;
  localparam logic signed [12:0] sp_under_div = 13'sh0001;
  localparam logic signed [12:0] dp_under_div = 13'sh0001;
  localparam logic signed [12:0] dp_sp_under = 13'sh0380;

  // Float-to-integer ranges on the unbiased magnitude exponent.
  localparam logic signed [12:0] sp_bias = 13'sh007f;
  localparam logic signed [12:0] dp_bias = 13'sh03ff;
  localparam logic signed [12:0] sp_exp_max = 13'sh00ff;
  localparam logic signed [12:0] dp_exp_max = 13'sh07ff;
  localparam logic signed [12:0] int_all_at = 13'sh0020;
  localparam logic signed [12:0] int_u_or_s_at = 13'sh001f;
  localparam logic signed [12:0] int_snz_at = 13'sh001e;

  // Float-to-integer response classes.
  typedef enum logic [4:0] {
    resp_none = 5'h00,
    resp_all = 5'h01,
    resp_signed = 5'h02,
    resp_signed_except_trunc = 5'h04,
    resp_unsigned = 5'h08,
    resp_unsigned_except_trunc = 5'h10
  } int_resp_t;

endpackage

// ===== rtl/fp_potential_exception_detector.sv
// Potential exception detector: flags instructions to bounce to support code.
// Assumes the issuing core supplies the initial biased result exponent per instruction,
// the operand signs for additions, and the float operand fields for integer conversions.
`timescale 1ns/1ps

// Notes on behaviour
// - Multiply-accumulate significands reach below four, exponent may rise by two.
// - Multiply-accumulate uses the add and multiply family threshold ranges.
// - Divide checks only the dividend minus divisor exponent, biased.
// - Divide never increments exponent but may decrement once in normalisation.
// - Divide overflow ranges equal the like-sign addition overflow ranges.
// - Divide bounces at quotient exponent 0x7fd double or 0xfd single and above.
// - Divide bounces at or below minimum normal, 0x01 single or 0x001 double.
// - Divide quotient exponent 0x02 single or 0x002 double is normal.
// - Square root never flags overflow or underflow.
// - Copy, absolute and negate never bounce.
// - Only double-to-single conversion flags range; single-to-double never does.
// - Double-to-single bounces at exponent 0x47d and above, normal at 0x47c.
// - Double-to-single bounces at exponent 0x380 and below, normal from 0x381.
// - Integer-to-float conversions never bounce on range.
// - Float-to-integer out-of-range is invalid operation, never overflow or underflow.
// - Float-to-integer thresholds depend on rounding mode, widest for signed truncation.
// - Response classes: all, signed, signed except trunc, unsigned, unsigned except trunc.
// - Like-sign and unlike-sign addition share overflow ranges; unlike-sign underflow ranges are more pessimistic.
module fp_potential_exception_detector
  import fp_bounce_pkg::*;
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic issue_valid,
  input wire fp_op_t issue_op,
  input wire logic double_prec,
  input wire logic flush_to_zero,
  input wire logic [1:0] round_mode,
  input wire logic sign_a,
  input wire logic sign_b,
  input wire logic signed [12:0] result_exp,
  input wire logic op_sign,
  input wire logic [10:0] op_exp,
  input wire logic op_mant_nonzero,
  output logic done,
  output logic bounce,
  output logic overflow_risk,
  output logic underflow_risk,
  output logic invalid_risk
);

  logic next_over;
  logic next_under;
  logic next_invalid;
  logic like_sign;
  logic signed [12:0] over_limit;
  logic signed [12:0] under_limit;
  logic signed [12:0] full_exp;
  logic signed [12:0] unbiased;
  logic is_nan_inf;
  logic is_signed_conv;
  logic is_trunc;
  int_resp_t int_class;

  // Subtraction flips the second sign, so like-sign means signs agree after that flip.
  assign like_sign = (sign_a == sign_b);

  // The like-sign overflow limit already carries the extra margin for a double increment,
  // so every arithmetic family shares one overflow comparator per precision.
  assign over_limit = double_prec ? dp_over_min : sp_over_min;

  always_comb begin
    under_limit = double_prec ? dp_under_like : sp_under_like;
    case (issue_op)
      add_family_op: begin
        if (!like_sign) begin
          under_limit = double_prec ? dp_under_unlike : sp_under_unlike;
        end
      end
      divide_op: begin
        // Normalisation may shift left once, so the minimum normal exponent also bounces.
        under_limit = double_prec ? dp_under_div : sp_under_div;
      end
      default: begin
        under_limit = double_prec ? dp_under_like : sp_under_like;
      end
    endcase
  end

  // Float-to-integer classification on the operand's own exponent.
  // Single precision keeps its exponent in the low eight bits; the upper bits are ignored.
  assign full_exp = double_prec ? {2'h0, op_exp} : {5'h00, op_exp[7:0]};
  assign unbiased = full_exp - (double_prec ? dp_bias : sp_bias);
  assign is_nan_inf = (full_exp == (double_prec ? dp_exp_max : sp_exp_max));
  assign is_signed_conv = (issue_op == float_to_signed) || (issue_op == float_to_signed_trunc);
  assign is_trunc = (issue_op == float_to_signed_trunc) ||
                    (issue_op == float_to_unsigned_trunc) || (round_mode == round_zero);

  always_comb begin
    int_class = resp_none;
    if (is_nan_inf || (unbiased >= int_all_at)) begin
      int_class = resp_all;
    end else if (op_sign) begin
      // Negative operands other than zero go to support code for unsigned results; the signed edge
      // at exactly minus two to the thirty-first is left pessimistic.
      if (unbiased >= int_u_or_s_at) begin
        int_class = resp_all;
      end else if (full_exp != 13'sh0000 || op_mant_nonzero) begin
        int_class = resp_unsigned;
      end else begin
        int_class = resp_none;
      end
    end else if (unbiased >= int_u_or_s_at) begin
      int_class = resp_signed;
    end else if (unbiased >= int_snz_at) begin
      int_class = resp_signed_except_trunc;
    end else begin
      int_class = resp_none;
    end
  end

  always_comb begin
    next_over = 1'b0;
    next_under = 1'b0;
    next_invalid = 1'b0;
    case (issue_op)
      add_family_op, multiply_family_op, mul_acc_op, mul_sub_acc_op, neg_mul_acc_op,
      neg_mul_sub_acc_op, divide_op: begin
        next_over = (result_exp >= over_limit);
        next_under = (result_exp <= under_limit) && !flush_to_zero;
      end
      double_to_single_conv: begin
        next_over = (result_exp >= dp_sp_over_min);
        next_under = (result_exp <= dp_sp_under) && !flush_to_zero;
      end
      float_to_unsigned, float_to_unsigned_trunc, float_to_signed, float_to_signed_trunc: begin
        case (int_class)
          resp_all: next_invalid = 1'b1;
          resp_signed: next_invalid = is_signed_conv;
          resp_signed_except_trunc: next_invalid = is_signed_conv && !is_trunc;
          resp_unsigned: next_invalid = !is_signed_conv;
          resp_unsigned_except_trunc: next_invalid = !is_signed_conv && !is_trunc;
          default: next_invalid = 1'b0;
        endcase
      end
      default: begin
        // Square root, copy, absolute, negate, widening, integer-to-float and compare.
        next_over = 1'b0;
        next_under = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      done <= 1'b0;
    end else begin
      done <= issue_valid;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      overflow_risk <= 1'b0;
      underflow_risk <= 1'b0;
      invalid_risk <= 1'b0;
      bounce <= 1'b0;
    end else begin
      overflow_risk <= issue_valid && next_over;
      underflow_risk <= issue_valid && next_under;
      invalid_risk <= issue_valid && next_invalid;
      bounce <= issue_valid && (next_over || next_under || next_invalid);
    end
  end

  div_over_a: assert property (@(posedge clock) disable iff (!rstn)
    issue_valid && issue_op == divide_op && double_prec && result_exp == 13'sh07fd
    |=> bounce && overflow_risk)
    else $error("divide at double overflow edge did not bounce");

  div_under_a: assert property (@(posedge clock) disable iff (!rstn)
    issue_valid && issue_op == divide_op && !double_prec && !flush_to_zero &&
    result_exp == 13'sh0001 |=> bounce && underflow_risk)
    else $error("divide at single minimum normal did not bounce");

  div_normal_a: assert property (@(posedge clock) disable iff (!rstn)
    issue_valid && issue_op == divide_op && result_exp == 13'sh0002 |=> !bounce)
    else $error("divide at exponent two bounced");

  narrow_over_a: assert property (@(posedge clock) disable iff (!rstn)
    issue_valid && issue_op == double_to_single_conv && result_exp == 13'sh047c
    |=> !overflow_risk)
    else $error("narrowing at 0x47c flagged overflow");

  narrow_under_a: assert property (@(posedge clock) disable iff (!rstn)
    issue_valid && issue_op == double_to_single_conv && !flush_to_zero &&
    result_exp == 13'sh0380 |=> underflow_risk)
    else $error("narrowing at 0x380 did not flag underflow");

  quiet_ops_a: assert property (@(posedge clock) disable iff (!rstn)
    issue_valid && (issue_op inside {copy_op, absolute_op, negate_op, square_root_op,
    single_to_double_conv, unsigned_int_to_float, signed_int_to_float}) |=> !bounce)
    else $error("range-safe operation bounced");

  int_invalid_a: assert property (@(posedge clock) disable iff (!rstn)
    issue_valid && (issue_op inside {float_to_unsigned, float_to_unsigned_trunc,
    float_to_signed, float_to_signed_trunc}) |=> !overflow_risk && !underflow_risk)
    else $error("float-to-integer flagged overflow or underflow");

  trunc_signed_a: assert property (@(posedge clock) disable iff (!rstn)
    issue_valid && issue_op == float_to_signed_trunc && !op_sign && !is_nan_inf &&
    unbiased == 13'sh001e |=> !bounce)
    else $error("signed truncation bounced in its widest range");

  bounce_cause_a: assert property (@(posedge clock) disable iff (!rstn)
    bounce |-> done && (overflow_risk || underflow_risk || invalid_risk))
    else $error("bounce without a cause");

  mac_over_a: assert property (@(posedge clock) disable iff (!rstn)
    issue_valid && issue_op == mul_acc_op && !double_prec && result_exp == 13'sh00fd
    |=> overflow_risk)
    else $error("multiply-accumulate at single overflow edge not flagged");

  mac_double_a: assert property (@(posedge clock) disable iff (!rstn)
    issue_valid && issue_op == mul_acc_op && double_prec && result_exp == 13'sh07fd
    |=> bounce && overflow_risk)
    else $error("multiply-accumulate at double overflow edge not flagged");

  mac_under_a: assert property (@(posedge clock) disable iff (!rstn)
    issue_valid && issue_op == neg_mul_acc_op && double_prec && !flush_to_zero &&
    result_exp == 13'sh0000 |=> underflow_risk)
    else $error("multiply-accumulate at zero exponent not flagged");

  mac_min_normal_a: assert property (@(posedge clock) disable iff (!rstn)
    issue_valid && issue_op == neg_mul_sub_acc_op && !double_prec &&
    result_exp == 13'sh0001 |=> !underflow_risk)
    else $error("multiply-accumulate at minimum normal flagged underflow");

  mul_below_over_a: assert property (@(posedge clock) disable iff (!rstn)
    issue_valid && issue_op == multiply_family_op && !double_prec &&
    result_exp == 13'sh00fc |=> !overflow_risk)
    else $error("multiply below single overflow edge flagged");

  div_single_over_a: assert property (@(posedge clock) disable iff (!rstn)
    issue_valid && issue_op == divide_op && !double_prec && result_exp == 13'sh00fd
    |=> bounce && overflow_risk)
    else $error("divide at single overflow edge did not bounce");

  div_single_edge_a: assert property (@(posedge clock) disable iff (!rstn)
    issue_valid && issue_op == divide_op && !double_prec && result_exp == 13'sh00fc
    |=> !overflow_risk)
    else $error("divide below single overflow edge flagged");

  div_double_edge_a: assert property (@(posedge clock) disable iff (!rstn)
    issue_valid && issue_op == divide_op && double_prec && result_exp == 13'sh07fc
    |=> !overflow_risk)
    else $error("divide below double overflow edge flagged");

  div_double_min_a: assert property (@(posedge clock) disable iff (!rstn)
    issue_valid && issue_op == divide_op && double_prec && !flush_to_zero &&
    result_exp == 13'sh0001 |=> bounce && underflow_risk)
    else $error("divide at double minimum normal did not bounce");

  div_negative_a: assert property (@(posedge clock) disable iff (!rstn)
    issue_valid && issue_op == divide_op && !flush_to_zero &&
    result_exp < 13'sh0000 |=> bounce && underflow_risk)
    else $error("divide with negative quotient exponent did not bounce");

  narrow_top_a: assert property (@(posedge clock) disable iff (!rstn)
    issue_valid && issue_op == double_to_single_conv && result_exp == 13'sh047d
    |=> bounce && overflow_risk)
    else $error("narrowing at 0x47d did not bounce");

  narrow_low_ok_a: assert property (@(posedge clock) disable iff (!rstn)
    issue_valid && issue_op == double_to_single_conv && result_exp == 13'sh0381
    |=> !underflow_risk)
    else $error("narrowing at 0x381 flagged underflow");

  narrow_ftz_a: assert property (@(posedge clock) disable iff (!rstn)
    issue_valid && issue_op == double_to_single_conv && flush_to_zero
    |=> !underflow_risk)
    else $error("narrowing flagged underflow while flushing");

  widen_quiet_a: assert property (@(posedge clock) disable iff (!rstn)
    issue_valid && issue_op == single_to_double_conv
    |=> !overflow_risk && !underflow_risk)
    else $error("widening flagged a range risk");

  int_to_float_a: assert property (@(posedge clock) disable iff (!rstn)
    issue_valid && (issue_op inside {unsigned_int_to_float, signed_int_to_float})
    |=> !bounce)
    else $error("integer-to-float conversion bounced");

  sqrt_quiet_a: assert property (@(posedge clock) disable iff (!rstn)
    issue_valid && issue_op == square_root_op
    |=> !overflow_risk && !underflow_risk)
    else $error("square root flagged a range risk");

  f2i_nan_a: assert property (@(posedge clock) disable iff (!rstn)
    issue_valid && (issue_op inside {float_to_unsigned, float_to_unsigned_trunc,
    float_to_signed, float_to_signed_trunc}) && is_nan_inf |=> bounce && invalid_risk)
    else $error("float-to-integer of a special value did not bounce");

  signed_edge_a: assert property (@(posedge clock) disable iff (!rstn)
    issue_valid && issue_op == float_to_signed && round_mode != round_zero && !op_sign &&
    !is_nan_inf && unbiased == 13'sh001e |=> invalid_risk)
    else $error("signed rounding conversion at upper range did not bounce");

  unsigned_neg_a: assert property (@(posedge clock) disable iff (!rstn)
    issue_valid && issue_op == float_to_unsigned_trunc && op_sign && !is_nan_inf &&
    full_exp != 13'sh0000 |=> invalid_risk)
    else $error("unsigned conversion of a negative value did not bounce");

  signed_neg_ok_a: assert property (@(posedge clock) disable iff (!rstn)
    issue_valid && issue_op == float_to_signed && op_sign && !is_nan_inf &&
    unbiased < 13'sh001f |=> !invalid_risk)
    else $error("signed conversion of a small negative value bounced");

  neg_zero_a: assert property (@(posedge clock) disable iff (!rstn)
    issue_valid && issue_op == float_to_unsigned && full_exp == 13'sh0000 &&
    !op_mant_nonzero |=> !bounce)
    else $error("unsigned conversion of zero bounced");

  like_under_a: assert property (@(posedge clock) disable iff (!rstn)
    issue_valid && issue_op == add_family_op && !double_prec && like_sign &&
    result_exp == 13'sh001f |=> !underflow_risk)
    else $error("like-sign addition at 0x1f flagged underflow");

  unlike_under_a: assert property (@(posedge clock) disable iff (!rstn)
    issue_valid && issue_op == add_family_op && !double_prec && !like_sign &&
    !flush_to_zero && result_exp == 13'sh001f |=> underflow_risk)
    else $error("unlike-sign addition at 0x1f not flagged");

  add_over_a: assert property (@(posedge clock) disable iff (!rstn)
    issue_valid && issue_op == add_family_op && double_prec && !like_sign &&
    result_exp == 13'sh07fd |=> overflow_risk)
    else $error("unlike-sign addition at double overflow edge not flagged");

  ftz_mask_a: assert property (@(posedge clock) disable iff (!rstn)
    issue_valid && flush_to_zero
    |=> !underflow_risk)
    else $error("underflow flagged while flushing to zero");

  idle_quiet_a: assert property (@(posedge clock) disable iff (!rstn)
    !issue_valid
    |=> !done && !bounce && !overflow_risk && !underflow_risk && !invalid_risk)
    else $error("output raised without an issued instruction");

  done_follow_a: assert property (@(posedge clock) disable iff (!rstn)
    issue_valid
    |=> done)
    else $error("issued instruction not answered");

  bounce_any_a: assert property (@(posedge clock) disable iff (!rstn)
    done && (overflow_risk || underflow_risk || invalid_risk)
    |-> bounce)
    else $error("detected risk without a bounce");

  compare_quiet_a: assert property (@(posedge clock) disable iff (!rstn)
    issue_valid && issue_op == compare_op
    |=> !bounce)
    else $error("compare bounced");

endmodule

// ===== tb/fp_host_issuer.sv
// Model of the issuing core: presents one instruction per send call.
// Assumes a single calling process; inputs change 2 ns after the rising edge.
`timescale 1ns/1ps
module fp_host_issuer
  import fp_bounce_pkg::*;
(
  input wire logic clock,
  output logic issue_valid,
  output fp_op_t issue_op,
  output logic double_prec,
  output logic flush_to_zero,
  output logic [1:0] round_mode,
  output logic sign_a,
  output logic sign_b,
  output logic signed [12:0] result_exp,
  output logic op_sign,
  output logic [10:0] op_exp,
  output logic op_mant_nonzero
);
  initial begin
    issue_valid = 1'b0;
    issue_op = add_family_op;
    {double_prec, flush_to_zero, round_mode, sign_a, sign_b} = 6'h00;
    {result_exp, op_sign, op_exp, op_mant_nonzero} = 26'h0000000;
  end

  task automatic send(input fp_op_t op, input logic dp, ftz, input logic [1:0] rm,
      input logic sa, sb, input logic signed [12:0] e, input logic os,
      input logic [10:0] oe, input logic onz);
    @(posedge clock);
    #2;
    issue_op = op;
    {double_prec, flush_to_zero, round_mode, sign_a, sign_b} = {dp, ftz, rm, sa, sb};
    {result_exp, op_sign, op_exp, op_mant_nonzero} = {e, os, oe, onz};
    issue_valid = 1'b1;
  endtask

  // Fields are scrambled while idle so a detector that ignores the valid bit is exposed.
  task automatic idle();
    @(posedge clock);
    #2;
    issue_valid = 1'b0;
    result_exp = ~result_exp;
    op_exp = ~op_exp;
  endtask
endmodule

// ===== tb/fp_potential_exception_detector_tb_top.sv
// Self-checking bench for the potential exception detector.
// Assumes the core model drives every detector input but clock and rstn; results are checked one cycle later.
`timescale 1ns/1ps
module fp_potential_exception_detector_tb_top;
  import fp_bounce_pkg::*;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic issue_valid, double_prec, flush_to_zero, sign_a, sign_b, op_sign, op_mant_nonzero;
  fp_op_t issue_op;
  logic [1:0] round_mode;
  logic signed [12:0] result_exp;
  logic [10:0] op_exp;
  logic done, bounce, overflow_risk, underflow_risk, invalid_risk;
  logic [4:0] got;
  logic [3:0] notes[$];
  int n_mismatch = 0;
  int n_tests = 0;
  int cycles = 0;
  fp_op_t quiet[7] = '{square_root_op, copy_op, absolute_op, negate_op,
    single_to_double_conv, unsigned_int_to_float, signed_int_to_float};
  fp_op_t f2i[4] = '{float_to_unsigned, float_to_unsigned_trunc, float_to_signed,
    float_to_signed_trunc};
  logic [31:0] r, q;

  always #25 clock = ~clock;

  fp_host_issuer host (.*);
  fp_potential_exception_detector dut (.*);

  function automatic logic [3:0] expect_of(fp_op_t op, logic dp, ftz, logic [1:0] rm,
      logic sa, sb, logic signed [12:0] e, logic os, logic [10:0] oe, logic onz);
    logic ov, un, inv, sg, tr;
    logic signed [12:0] x, ue, top;
    {ov, un, inv} = 3'h0;
    sg = (op == float_to_signed) || (op == float_to_signed_trunc);
    tr = (op == float_to_unsigned_trunc) || (op == float_to_signed_trunc) || (rm == 2'h3);
    x = dp ? {2'h0, oe} : {5'h00, oe[7:0]};
    ue = x - (dp ? 13'sh3ff : 13'sh07f);
    top = dp ? 13'sh7fd : 13'sh0fd;
    case (op)
      add_family_op: begin
        ov = e >= top;
        un = e <= ((sa == sb) ? 13'sh000 : (dp ? 13'sh03f : 13'sh01f));
      end
      multiply_family_op, mul_acc_op, mul_sub_acc_op, neg_mul_acc_op, neg_mul_sub_acc_op: begin
        ov = e >= top;
        un = e <= 13'sh000;
      end
      divide_op: begin
        ov = e >= top;
        un = e <= 13'sh001;
      end
      double_to_single_conv: begin
        ov = e >= 13'sh47d;
        un = e <= 13'sh380;
      end
      float_to_unsigned, float_to_unsigned_trunc, float_to_signed, float_to_signed_trunc: begin
        if (x == (dp ? 13'sh7ff : 13'sh0ff) || ue >= 32 || (os && ue >= 31)) inv = 1'b1;
        else if (os) inv = !sg && (x != 0 || onz);
        else inv = sg && (ue == 31 || (ue == 30 && !tr));
      end
      default: ;
    endcase
    un = un && !ftz;
    return {ov || un || inv, ov, un, inv};
  endfunction

  task automatic chk(input logic [4:0] got, input logic [4:0] want);
    n_tests++;
    if (got !== want) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask

  task automatic full(input fp_op_t op, input logic dp, ftz, input logic [1:0] rm,
      input logic sa, sb, input logic signed [12:0] e, input logic os,
      input logic [10:0] oe, input logic onz);
    notes.push_back(expect_of(op, dp, ftz, rm, sa, sb, e, os, oe, onz));
    host.send(op, dp, ftz, rm, sa, sb, e, os, oe, onz);
  endtask

  task automatic go(input fp_op_t op, input logic dp, input logic signed [12:0] e,
      input logic ftz = 1'b0, input logic sa = 1'b0, input logic sb = 1'b0);
    full(op, dp, ftz, 2'h0, sa, sb, e, 1'b0, 11'h000, 1'b0);
  endtask

  task automatic give_verdict();
    $display("tests=%0d mismatches=%0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // Checked on the falling edge so registered outputs have settled.
  always @(negedge clock) begin
    got = {done, bounce, overflow_risk, underflow_risk, invalid_risk};
    if (rstn !== 1'b1 || done !== 1'b1) chk(got, 5'h00);
    else if (notes.size() == 0) chk(got, 5'h00);
    else chk(got, {1'b1, notes.pop_front()});
  end

  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      n_mismatch++;
      give_verdict();
    end
  end

  initial begin
    void'($urandom(5472));
    repeat (4) @(posedge clock);
    #2;
    rstn = 1'b1;
    go(divide_op, 1, 13'sh7fd);
    go(divide_op, 1, 13'sh7fc);
    go(divide_op, 0, 13'sh0fd);
    go(divide_op, 0, 13'sh0fc);
    go(divide_op, 1, 13'sh001);
    go(divide_op, 0, 13'sh001);
    go(divide_op, 1, 13'sh002);
    go(divide_op, 0, 13'sh002);
    go(divide_op, 1, -13'sh005);
    go(double_to_single_conv, 1, 13'sh47d);
    go(double_to_single_conv, 1, 13'sh47c);
    go(double_to_single_conv, 1, 13'sh381);
    go(double_to_single_conv, 1, 13'sh380);
    go(double_to_single_conv, 1, 13'sh380, 1'b1);
    go(mul_acc_op, 1, 13'sh7fd);
    go(mul_acc_op, 0, 13'sh0fd);
    go(mul_sub_acc_op, 0, 13'sh0fd);
    go(neg_mul_acc_op, 1, 13'sh000);
    go(neg_mul_sub_acc_op, 0, 13'sh001);
    go(multiply_family_op, 0, 13'sh0fc);
    go(add_family_op, 0, 13'sh01f, 1'b0, 1'b0, 1'b1);
    go(add_family_op, 0, 13'sh01f, 1'b0, 1'b1, 1'b1);
    go(add_family_op, 1, 13'sh7fd, 1'b0, 1'b0, 1'b1);
    foreach (quiet[i]) begin
      go(quiet[i], 1, 13'sh7ff);
      go(quiet[i], 0, -13'sh040);
    end
    for (int m = 0; m < 4; m++) begin
      for (int k = 0; k < 4; k++) begin
        full(f2i[k], 1, 0, m[1:0], 0, 0, 0, 1'b0, 11'h41d, 1'b1);
        full(f2i[k], 0, 0, m[1:0], 0, 0, 0, 1'b0, 11'h09e, 1'b0);
        full(f2i[k], 1, 0, m[1:0], 0, 0, 0, 1'b1, 11'h3ff, 1'b0);
        full(f2i[k], 0, 0, m[1:0], 0, 0, 0, 1'b0, 11'h0ff, 1'b1);
      end
    end
    full(float_to_unsigned, 1, 0, 2'h0, 0, 0, 0, 1'b1, 11'h000, 1'b0);
    // A reset landing while a bounce is shown must clear it at once.
    go(divide_op, 1, 13'sh7ff);
    host.idle();
    rstn = 1'b0;
    notes.delete();
    @(posedge clock);
    #2;
    rstn = 1'b1;
    repeat (300) begin
      r = $urandom;
      q = $urandom;
      if (r[31]) host.idle();
      full(fp_op_t'(5'(r[4:0] % 20)), r[5], r[6], r[8:7], r[9], r[10], r[23:11], r[24],
        q[10:0], r[25]);
    end
    host.idle();
    repeat (3) @(posedge clock);
    chk(5'(notes.size()), 5'h00);
    give_verdict();
  end
endmodule
